/* File: verilog/td_field_map.vh */
`ifndef TD_FIELD_MAP_VH
`define TD_FIELD_MAP_VH
// apb register byte offsets
`define REG_HDR_LO      8'h00
`define REG_HDR_HI      8'h04
`define REG_CTRL        8'h08
`define REG_STATUS      8'h0C
`define REG_RESULT      8'h10
`define REG_TOKEN       8'h14
// header low word: bytes 0..3
`define F_MOVED_LO      0
`define F_RESULT_LO     12
`define F_ACTIVE        11
`define F_TOGGLE        10
`define F_LIMIT_LO      16
`define F_SPEED         26
`define F_LAST          27
`define F_EP_LO         28
// header high word: bytes 4..7
`define F_TOTAL_LO      0
`define F_DIR_LO        10
`define F_PACING        13
`define F_FUNC_LO       16
`define F_FORMAT        23
// result codes
`define RES_OK          4'h0
`define RES_NO_REPLY    4'h5
`define RES_RSVD_A      4'hA
`define RES_RSVD_B      4'hB
`define RES_STORE_SLOW  4'hC
`define RES_FETCH_SLOW  4'hD
// token codes
`define TOK_SETUP       2'h0
`define TOK_OUT         2'h1
`define TOK_IN          2'h2
`define TOK_RSVD        2'h3
// frame timing
`define FRAME_NS        1000000
`define CLK_NS          40
`define FRAME_CYCLES    (`FRAME_NS / `CLK_NS)
`endif

/* File: verilog/td_engine.v */
// Overview of operation
// - write result code 0000 when a transfer ends with no detected error
// - record bytes actually moved in the ten-bit moved count field
// - report 0101 when endpoint gives no reply or handshake
// - report 1100 when IN data arrives faster than memory can store it
// - report 1101 when OUT data cannot be fetched fast enough
// - clear execute-enable when the descriptor's transaction completes
// - toggle bit picks DATA0/DATA1 on send; the received data PID is not checked
// - flip toggle after every successful data packet
// - each packet limited to the ten-bit packet byte limit
// - address endpoint with the four-bit endpoint index
// - list-end bit one marks the final descriptor of the list
// - move total byte count; above packet limit only for bulk/control
// - pacing bit reads zero after power-on reset
// - with pacing set on interrupt endpoint, one transaction per 1 ms frame
// - format zero means control, bulk or interrupt descriptor
// - format one means isochronous descriptor
// - address function with the seven-bit target function address
`timescale 1ns/10ps
`include "td_field_map.vh"
module td_engine
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        pkt_done_in,
    input  wire        pkt_no_reply_in,
    input  wire        pkt_store_slow_in,
    input  wire        pkt_fetch_slow_in,
    input  wire [9:0]  pkt_bytes_in,
    output reg         tok_start_r,
    output reg  [1:0]  token_direction_r,
    output reg         data_pid_one_r,
    output reg  [6:0]  target_function_addr_r,
    output reg  [3:0]  endpoint_index_r,
    output reg         low_speed_r,
    output reg  [9:0]  pkt_len_r,
    output reg         iso_mode_r,
    output reg         list_end_r
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_DONE = 2'd2;
    localparam [31:0] FRAME_SPAN = `FRAME_CYCLES - 1; // kept full width, cut to the counter below

    // descriptor fields held as the controller's working copy
    reg        active_r;
    reg        toggle_r;
    reg [3:0]  result_code_r;
    reg [9:0]  bytes_moved_count_r;
    reg [9:0]  packet_byte_limit_r;
    reg [3:0]  ep_r;
    reg        speed_r;
    reg        last_r;
    reg [9:0]  transfer_byte_count_r;
    reg [1:0]  dir_r;
    reg        interrupt_pacing_bit_r;
    reg [6:0]  func_r;
    reg        format_r;
    reg [1:0]  state_r;
    reg [15:0] frame_cnt_r;
    reg        sent_in_frame_r;
    reg        done_r;
    // pins from the link side run on another clock, so synchronise them
    reg [4:0]  ev_meta_r;
    reg [4:0]  ev_sync_r;
    reg [4:0]  ev_prev_r;
    reg [9:0]  bytes_meta_r;
    reg [9:0]  bytes_sync_r;

    wire       wr_en  = psel & penable & pwrite;
    wire [4:0] ev_new = ev_sync_r & ~ev_prev_r;
    wire       frame_tick = (frame_cnt_r == FRAME_SPAN[15:0]);
    wire [9:0] remain = transfer_byte_count_r - bytes_moved_count_r;
    wire       pace_block = interrupt_pacing_bit_r & ~format_r & sent_in_frame_r;

    // never lets a reserved code through; the two reserved codes fall back to no reply, others pass unchanged
    function [3:0] safe_code;
        input [3:0] c;
        begin
            if (c == `RES_RSVD_A || c == `RES_RSVD_B)
                safe_code = `RES_NO_REPLY;
            else
                safe_code = c;
        end
    endfunction

    // packet length: isochronous and interrupt packets never exceed one packet limit
    function [9:0] next_len;
        input [9:0] rem;
        input [9:0] lim;
        begin
            if (rem > lim)
                next_len = lim;
            else
                next_len = rem;
        end
    endfunction

    // two-flop synchronisers and edge detection on the second stage only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_meta_r    <= 5'h00;
            ev_sync_r    <= 5'h00;
            ev_prev_r    <= 5'h00;
            bytes_meta_r <= 10'h000;
            bytes_sync_r <= 10'h000;
        end
        else
        begin
            ev_meta_r    <= {pkt_fetch_slow_in, pkt_store_slow_in, pkt_no_reply_in, pkt_done_in, 1'b0};
            ev_sync_r    <= ev_meta_r;
            ev_prev_r    <= ev_sync_r;
            bytes_meta_r <= pkt_bytes_in;
            bytes_sync_r <= bytes_meta_r;
        end
    end

    // 1 ms frame timer sets the pacing window
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_cnt_r <= 16'h0000;
        else if (frame_tick)
            frame_cnt_r <= 16'h0000;
        else
            frame_cnt_r <= frame_cnt_r + 16'h0001;
    end

    // descriptor fields, transaction sequencer and result write-back
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_r               <= 1'b0;
            toggle_r               <= 1'b0;
            result_code_r          <= `RES_OK;
            bytes_moved_count_r    <= 10'h000;
            packet_byte_limit_r    <= 10'h000;
            ep_r                   <= 4'h0;
            speed_r                <= 1'b0;
            last_r                 <= 1'b0;
            transfer_byte_count_r  <= 10'h000;
            dir_r                  <= 2'h0;
            interrupt_pacing_bit_r <= 1'b0;
            func_r                 <= 7'h00;
            format_r               <= 1'b0;
            state_r                <= ST_IDLE;
            sent_in_frame_r        <= 1'b0;
            done_r                 <= 1'b0;
            tok_start_r            <= 1'b0;
            token_direction_r      <= `TOK_SETUP;
            data_pid_one_r         <= 1'b0;
            target_function_addr_r <= 7'h00;
            endpoint_index_r       <= 4'h0;
            low_speed_r            <= 1'b0;
            pkt_len_r              <= 10'h000;
            iso_mode_r             <= 1'b0;
            list_end_r             <= 1'b0;
        end
        else
        begin
            tok_start_r <= 1'b0;
            if (frame_tick)
                sent_in_frame_r <= 1'b0;
            // writes are refused while a transaction runs; firmware arms with active
            if (wr_en && state_r == ST_IDLE && paddr == `REG_HDR_LO)
            begin
                active_r            <= pwdata[`F_ACTIVE];
                toggle_r            <= pwdata[`F_TOGGLE];
                packet_byte_limit_r <= pwdata[`F_LIMIT_LO +: 10];
                speed_r             <= pwdata[`F_SPEED];
                last_r              <= pwdata[`F_LAST];
                ep_r                <= pwdata[`F_EP_LO +: 4];
                bytes_moved_count_r <= 10'h000;
                result_code_r       <= `RES_OK;
                done_r              <= 1'b0;
            end
            if (wr_en && state_r == ST_IDLE && paddr == `REG_HDR_HI)
            begin
                transfer_byte_count_r  <= pwdata[`F_TOTAL_LO +: 10];
                dir_r                  <= pwdata[`F_DIR_LO +: 2];
                interrupt_pacing_bit_r <= pwdata[`F_PACING];
                func_r                 <= pwdata[`F_FUNC_LO +: 7];
                format_r               <= pwdata[`F_FORMAT];
            end
            case (state_r)
                ST_IDLE:
                begin
                    if (active_r && !done_r && dir_r == `TOK_RSVD)
                    begin
                        result_code_r <= safe_code(`RES_NO_REPLY);
                        active_r      <= 1'b0;
                        done_r        <= 1'b1;
                    end
                    else if (active_r && !done_r && !pace_block)
                    begin
                        tok_start_r            <= 1'b1;
                        token_direction_r      <= dir_r;
                        data_pid_one_r         <= toggle_r;
                        target_function_addr_r <= func_r;
                        endpoint_index_r       <= ep_r;
                        low_speed_r            <= speed_r;
                        iso_mode_r             <= format_r;
                        list_end_r             <= last_r;
                        pkt_len_r              <= next_len(remain, packet_byte_limit_r);
                        sent_in_frame_r        <= 1'b1;
                        state_r                <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (ev_new[2])
                    begin
                        result_code_r <= safe_code(`RES_NO_REPLY);
                        state_r       <= ST_DONE;
                    end
                    else if (ev_new[3])
                    begin
                        result_code_r <= safe_code(`RES_STORE_SLOW);
                        state_r       <= ST_DONE;
                    end
                    else if (ev_new[4])
                    begin
                        result_code_r <= safe_code(`RES_FETCH_SLOW);
                        state_r       <= ST_DONE;
                    end
                    else if (ev_new[1])
                    begin
                        bytes_moved_count_r <= bytes_moved_count_r + bytes_sync_r;
                        toggle_r            <= ~toggle_r;
                        // only bulk and control run past one packet
                        if (format_r || dir_r == `TOK_SETUP || interrupt_pacing_bit_r ||
                            bytes_sync_r < pkt_len_r ||
                            bytes_moved_count_r + bytes_sync_r >= transfer_byte_count_r)
                        begin
                            result_code_r <= safe_code(`RES_OK);
                            state_r       <= ST_DONE;
                        end
                        else
                            state_r <= ST_IDLE;
                    end
                end
                ST_DONE:
                begin
                    active_r <= 1'b0;
                    done_r   <= 1'b1;
                    state_r  <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // apb slave: zero wait states, unmapped addresses answer with pslverr
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable)
            begin
                case (paddr)
                    `REG_HDR_LO:
                        prdata <= {ep_r, last_r, speed_r, packet_byte_limit_r,
                                   result_code_r, active_r, toggle_r, bytes_moved_count_r};
                    `REG_HDR_HI:
                        prdata <= {8'h00, format_r, func_r, 2'h0, interrupt_pacing_bit_r,
                                   1'b0, dir_r, transfer_byte_count_r};
                    `REG_STATUS:
                        prdata <= {28'h0000000, done_r, sent_in_frame_r, state_r};
                    `REG_RESULT:
                        prdata <= {18'h00000, result_code_r, bytes_moved_count_r};
                    `REG_TOKEN:
                        prdata <= {10'h000, iso_mode_r, list_end_r, low_speed_r, data_pid_one_r,
                                   token_direction_r, endpoint_index_r, 5'h00, target_function_addr_r};
                    `REG_CTRL:
                        prdata <= 32'h00000000;
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

/* File: dv/td_engine_chk.sv */
`timescale 1ns/10ps
`include "td_field_map.vh"
module td_engine_chk
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tok_start_r,
    input wire [1:0]  token_direction_r,
    input wire [6:0]  target_function_addr_r,
    input wire [3:0]  endpoint_index_r,
    input wire        low_speed_r,
    input wire [9:0]  pkt_len_r,
    input wire        iso_mode_r,
    input wire        list_end_r
);
    reg [31:0] lo_r;
    reg [31:0] hi_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the last header words; busy-time writes are never issued
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            lo_r <= 32'h0;
            hi_r <= 32'h0;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == `REG_HDR_LO) lo_r <= pwdata;
            if (paddr == `REG_HDR_HI) hi_r <= pwdata;
        end
    property p_dir; tok_start_r |-> token_direction_r == hi_r[11:10] && token_direction_r != `TOK_RSVD; endproperty
    a_dir: assert property (p_dir) else $error("token kind wrong");
    property p_len; tok_start_r |-> pkt_len_r <= lo_r[25:16]; endproperty
    a_len: assert property (p_len) else $error("packet above limit");
    property p_tot; tok_start_r |-> pkt_len_r <= hi_r[9:0]; endproperty
    a_tot: assert property (p_tot) else $error("packet above total");
    property p_func; tok_start_r |-> target_function_addr_r == hi_r[22:16]; endproperty
    a_func: assert property (p_func) else $error("function address wrong");
    property p_ep; tok_start_r |-> endpoint_index_r == lo_r[31:28]; endproperty
    a_ep: assert property (p_ep) else $error("endpoint wrong");
    property p_spd; tok_start_r |-> low_speed_r == lo_r[26]; endproperty
    a_spd: assert property (p_spd) else $error("speed wrong");
    property p_fmt; tok_start_r |-> iso_mode_r == hi_r[23] && list_end_r == lo_r[27]; endproperty
    a_fmt: assert property (p_fmt) else $error("format or last wrong");
    // both reserved codes share the pattern 101x
    property p_res; pready && !pwrite && paddr == `REG_HDR_LO |-> prdata[15:13] != 3'h5; endproperty
    a_res: assert property (p_res) else $error("reserved result code");
    property p_rdy; psel && !penable |=> pready && pslverr == (paddr > `REG_TOKEN); endproperty
    a_rdy: assert property (p_rdy) else $error("bus answer wrong");
    c_tok: cover property (tok_start_r);
    c_iso: cover property (tok_start_r && iso_mode_r);
    c_err: cover property (pready && pslverr);
endmodule
bind td_engine td_engine_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok_start_r(tok_start_r), .token_direction_r(token_direction_r), .low_speed_r(low_speed_r),
    .target_function_addr_r(target_function_addr_r), .endpoint_index_r(endpoint_index_r),
    .pkt_len_r(pkt_len_r), .iso_mode_r(iso_mode_r), .list_end_r(list_end_r));

/* File: dv/usb_ep_model.sv */
`timescale 1ns/10ps
module usb_ep_model
(
    input  wire       pclk,
    input  wire       tok_start,
    input  wire [9:0] pkt_len,
    input  wire [1:0] mode,
    input  wire [3:0] dly,
    output reg        done,
    output reg        no_reply,
    output reg        fault_a,
    output reg        fault_b,
    output reg  [9:0] bytes
);
    reg [9:0] len;
    reg [4:0] cnt;
    initial
    begin
        {done, no_reply, fault_a, fault_b} = 4'h0;
        bytes = 10'h3FF;
        len = 10'h000;
        cnt = 5'h00;
    end
    // answer a token after dly cycles (at least one); mode picks success or one fault
    // a countdown, not waits, so a token that follows the answer closely is never missed
    always @(posedge pclk)
    begin
        if (tok_start)
        begin
            len <= pkt_len;
            cnt <= {1'b0, dly} + 5'h05;
        end
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
        if (cnt == 5'h06)
        begin
            bytes <= len;
            {fault_b, fault_a, no_reply, done} <= 4'h1 << mode;
        end
        else if (cnt == 5'h02)
            {done, no_reply, fault_a, fault_b} <= 4'h0;
        else if (cnt == 5'h01)
            bytes <= ~len; // count is void once the event line drops
    end
endmodule

/* File: dv/test_host_transfer_descriptor_fields.sv */
`timescale 1ns/10ps
`include "td_field_map.vh"
module test_host_transfer_descriptor_fields;
    reg         pclk, presetn, psel, penable, pwrite, rerr;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [1:0]  mode;
    reg  [3:0]  dly;
    wire [31:0] prdata;
    wire        pready, pslverr, dn, nr, fa_w, fb_w, tok, pid, low, iso, last;
    wire [9:0]  bytes, len;
    wire [1:0]  dir;
    wire [6:0]  fa;
    wire [3:0]  ep;
    integer     err_count, comparisons, ntok, n0, i;
    td_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pkt_done_in(dn), .pkt_no_reply_in(nr), .pkt_store_slow_in(fa_w), .pkt_fetch_slow_in(fb_w),
        .pkt_bytes_in(bytes), .tok_start_r(tok), .token_direction_r(dir), .data_pid_one_r(pid),
        .target_function_addr_r(fa), .endpoint_index_r(ep), .low_speed_r(low), .pkt_len_r(len),
        .iso_mode_r(iso), .list_end_r(last));
    usb_ep_model ep_m (.pclk(pclk), .tok_start(tok), .pkt_len(len), .mode(mode), .dly(dly), .done(dn),
        .no_reply(nr), .fault_a(fa_w), .fault_b(fb_w), .bytes(bytes));
    always #20 pclk = ~pclk;
    // tokens counted to see how many packets a descriptor caused
    always @(posedge pclk)
        if (tok === 1'b1) ntok <= ntok + 1;
    task finish_test;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    // request stands until pready is sampled high at a rising edge; data are taken at that edge
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask
    function [31:0] lo_w(input [3:0] e, input l, input s, input [9:0] lim, input t);
        lo_w = {e, l, s, lim, 4'h0, 1'b1, t, 10'h000};
    endfunction
    function [31:0] hi_w(input f, input [6:0] a, input p, input [1:0] d, input [9:0] tot);
        hi_w = {8'h00, f, a, 2'h0, p, 1'b0, d, tot};
    endfunction
    task start(input [31:0] lo, input [31:0] hi, input [1:0] m);
    begin
        mode <= m;
        n0 = ntok;
        apb(1'b1, `REG_HDR_HI, hi);
        apb(1'b1, `REG_HDR_LO, lo);
    end
    endtask
    // e holds {result, active, toggle, moved} as the finished header must read
    task finish(input [15:0] e);
    begin
        rd = 32'h0;
        for (i = 0; i < 20000 && rd[3] !== 1'b1; i = i + 1)
            apb(1'b0, `REG_STATUS, 32'h0);
        apb(1'b0, `REG_HDR_LO, 32'h0);
        chk("hdr_lo", {16'h0, e}, rd & 32'h0000FFFF);
    end
    endtask
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, mode} = 'h0;
        {err_count, comparisons, ntok, n0} = 0;
        dly = 4'h1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `REG_HDR_HI, 32'h0);
        chk("pacing", 32'h0, rd[13]);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, rerr);
        $display("test reset done");
        start(lo_w(4'h3, 1'b1, 1'b1, 10'h008, 1'b0), hi_w(1'b1, 7'h05, 1'b0, `TOK_IN, 10'h008), 2'h0);
        finish({`RES_OK, 2'h1, 10'h008});
        $display("test single done");
        dly = 4'h9;
        start(lo_w(4'hA, 1'b0, 1'b0, 10'h008, 1'b0), hi_w(1'b0, 7'h7F, 1'b0, `TOK_OUT, 10'h014), 2'h0);
        finish({`RES_OK, 2'h1, 10'h014});
        chk("tokens", 32'h3, ntok - n0);
        $display("test bulk done");
        dly = 4'h2;
        start(lo_w(4'h1, 1'b0, 1'b0, 10'h010, 1'b1), hi_w(1'b0, 7'h11, 1'b0, `TOK_SETUP, 10'h010), 2'h1);
        finish({`RES_NO_REPLY, 2'h1, 10'h000});
        chk("pid", 32'h1, pid);
        apb(1'b0, `REG_TOKEN, 32'h0);
        chk("token", 32'h00041011, rd);
        start(lo_w(4'h2, 1'b0, 1'b0, 10'h010, 1'b1), hi_w(1'b0, 7'h22, 1'b0, `TOK_IN, 10'h010), 2'h2);
        finish({`RES_STORE_SLOW, 2'h1, 10'h000});
        start(lo_w(4'h4, 1'b0, 1'b0, 10'h010, 1'b1), hi_w(1'b0, 7'h44, 1'b0, `TOK_OUT, 10'h010), 2'h3);
        finish({`RES_FETCH_SLOW, 2'h1, 10'h000});
        start(lo_w(4'h4, 1'b0, 1'b0, 10'h010, 1'b0), hi_w(1'b0, 7'h44, 1'b0, `TOK_RSVD, 10'h010), 2'h0);
        finish({`RES_NO_REPLY, 2'h0, 10'h000});
        chk("tokens", 32'h0, ntok - n0);
        $display("test faults done");
        start(lo_w(4'h5, 1'b0, 1'b0, 10'h008, 1'b0), hi_w(1'b0, 7'h09, 1'b1, `TOK_IN, 10'h008), 2'h0);
        finish({`RES_OK, 2'h1, 10'h008});
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("in_frame", 32'h1, rd[2]);
        start(lo_w(4'h5, 1'b0, 1'b0, 10'h008, 1'b1), hi_w(1'b0, 7'h09, 1'b1, `TOK_IN, 10'h008), 2'h0);
        repeat (50) @(posedge pclk);
        chk("tokens", 32'h0, ntok - n0);
        finish({`RES_OK, 2'h0, 10'h008});
        $display("test pacing done");
        finish_test;
    end
    // paced descriptors wait for two frame ticks, so the run needs about 50000 cycles; 75000 means a hang
    initial
    begin
        #3000000;
        err_count = err_count + 1;
        finish_test;
    end
endmodule
